// ---- design/lech_ctrl.sv ----
`timescale 1ns/1ps
`include "lech_map.svh"
// Function
// - hold-enable set: counter stops at 0xFF until software clears it
// - hold-enable clear: counter wraps past 0xFF
// - bit2 unexpected control char, bit1 invalid symbol, bit0 disparity
// - lane 4 field bits [2:0], reset 0x7, bits [7:3] read zero
// - lane 5 independent field, same meaning, reset 0x7
// - per-counter flag set when counter reaches 0xFF
module lech_ctrl (
   input wire logic clock, // 200 MHz
   input wire logic reset_n, // async, active low
   input wire logic clk_en, // freezes all state when low
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   input wire logic [11:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // write data
   output logic [7:0] reg_rdata, // read data, one cycle after reg_rd
   input wire logic [1:0] lane_enable, // lane 5, lane 4 enables
   input wire lech_pkg::lech_err_t [1:0] lane_err, // per-lane error pulses
   input wire logic [1:0][2:0] count_clear, // software counter reset
   output logic [1:0][2:0][7:0] err_count, // counter values
   output logic [1:0][2:0] sat_flag, // terminal count reached
   output logic decoder_soft_reset // held decoder reset level
);
   lech_pkg::lech_state_t s_q, s_d;
   logic [1:0][2:0] hold;

   assign hold[0] = s_q.lane4_saturate_enable;
   assign hold[1] = s_q.lane5_saturate_enable;

   always_comb begin
      logic [2:0] ev;
      logic [7:0] c;
      ev = 3'h0;
      c = 8'h00;
      s_d = s_q;
      s_d.rdata = 8'h00;
      if (reg_wr && reg_addr == `LECH_OFS_DEC_CTRL) begin
         s_d.decoder_soft_reset = reg_wdata[`LECH_DEC_SRST_BIT];
      end
      // hold-field writes outside soft reset are dropped to keep counters consistent
      if (reg_wr && s_q.decoder_soft_reset) begin
         if (reg_addr == `LECH_OFS_HOLD4) begin
            s_d.lane4_saturate_enable = reg_wdata[2:0];
         end
         if (reg_addr == `LECH_OFS_HOLD5) begin
            s_d.lane5_saturate_enable = reg_wdata[2:0];
         end
      end
      if (reg_rd) begin
         case (reg_addr)
            `LECH_OFS_HOLD4: s_d.rdata = {5'h00, s_q.lane4_saturate_enable};
            `LECH_OFS_HOLD5: s_d.rdata = {5'h00, s_q.lane5_saturate_enable};
            `LECH_OFS_DEC_CTRL: s_d.rdata = {4'h0, s_q.decoder_soft_reset, 3'h0};
            default: s_d.rdata = 8'h00;
         endcase
      end
      for (int l = 0; l < 2; l++) begin
         ev = {lane_err[l].unexpected_control_char_error,
               lane_err[l].invalid_symbol_error,
               lane_err[l].running_disparity_error};
         for (int k = 0; k < 3; k++) begin
            c = s_q.count[l*3+k];
            if (ev[k] && lane_enable[l] && !s_q.decoder_soft_reset) begin
               if (c == `LECH_TERMINAL && hold[l][k]) begin
                  c = c;
               end else begin
                  c = c + 8'h01;
               end
            end
            if (c == `LECH_TERMINAL) begin
               s_d.saturated_flag[l][k] = 1'b1;
            end
            if (count_clear[l][k]) begin
               c = 8'h00;
               s_d.saturated_flag[l][k] = 1'b0;
            end
            s_d.count[l*3+k] = c;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{lane4_saturate_enable: `LECH_HOLD_RESET,
                  lane5_saturate_enable: `LECH_HOLD_RESET,
                  decoder_soft_reset: 1'b1, default: '0};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   always_comb begin
      for (int l = 0; l < 2; l++) begin
         for (int k = 0; k < 3; k++) begin
            err_count[l][k] = s_q.count[l*3+k];
         end
      end
   end
   assign sat_flag = s_q.saturated_flag;
   assign reg_rdata = s_q.rdata;
   assign decoder_soft_reset = s_q.decoder_soft_reset;

   a_hold_stays: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && hold[0][0] && err_count[0][0] == 8'hFF && !count_clear[0][0])
      |=> err_count[0][0] == 8'hFF)
      else $error("held counter left terminal count");
   a_wrap_zero: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && !hold[0][2] && err_count[0][2] == 8'hFF && lane_enable[0]
       && lane_err[0].unexpected_control_char_error && !count_clear[0][2]
       && !decoder_soft_reset) |=> err_count[0][2] == 8'h00)
      else $error("counter did not wrap");
   a_wr_blocked: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && !decoder_soft_reset && !(reg_wr && reg_addr == `LECH_OFS_DEC_CTRL))
      |=> $stable(hold))
      else $error("hold field changed outside soft reset");
   a_flag_set: assert property (@(posedge clock) disable iff (!reset_n)
      (err_count[1][1] == 8'hFF) |-> sat_flag[1][1])
      else $error("flag missing at terminal count");
   a_count_inc: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && lane_enable[1] && lane_err[1].invalid_symbol_error && !decoder_soft_reset
       && !count_clear[1][1] && err_count[1][1] < 8'hFE)
      |=> err_count[1][1] == $past(err_count[1][1]) + 8'h01)
      else $error("counter did not increment");
   a_read_hold: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && reg_rd && reg_addr == `LECH_OFS_HOLD4)
      |=> reg_rdata == {5'h00, $past(hold[0])})
      else $error("lane 4 read mismatch");
   a_lane5_read: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && reg_rd && reg_addr == `LECH_OFS_HOLD5)
      |=> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] == $past(hold[1]))
      else $error("lane 5 read mismatch");
   a_bit_order: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && hold[1][2] && err_count[1][2] == 8'hFF && !count_clear[1][2])
      |=> err_count[1][2] == 8'hFF && sat_flag[1][2])
      else $error("bit 2 does not govern control-char counter");

   // register port checks
   a_hold4_write: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && reg_wr && decoder_soft_reset && reg_addr == `LECH_OFS_HOLD4)
      |=> hold[0] == $past(reg_wdata[2:0]))
      else $error("lane 4 hold write lost");

   a_hold5_write: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && reg_wr && decoder_soft_reset && reg_addr == `LECH_OFS_HOLD5)
      |=> hold[1] == $past(reg_wdata[2:0]))
      else $error("lane 5 hold write lost");

   a_srst_write: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && reg_wr && reg_addr == `LECH_OFS_DEC_CTRL)
      |=> decoder_soft_reset == $past(reg_wdata[`LECH_DEC_SRST_BIT]))
      else $error("soft reset write lost");

   a_ctrl_read: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && reg_rd && reg_addr == `LECH_OFS_DEC_CTRL)
      |=> reg_rdata == {4'h0, $past(decoder_soft_reset), 3'h0})
      else $error("control read mismatch");

   // unmapped and idle reads must not leak stale data
   a_unmapped_read: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && reg_rd && reg_addr != `LECH_OFS_HOLD4 && reg_addr != `LECH_OFS_HOLD5
       && reg_addr != `LECH_OFS_DEC_CTRL) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   a_rdata_idle: assert property (@(posedge clock) disable iff (!reset_n)
      (clk_en && !reg_rd) |=> reg_rdata == 8'h00)
      else $error("read data not zero when idle");

   // every counter of both lanes checked alike
   for (genvar gl = 0; gl < 2; gl++) begin : g_lane
      for (genvar gk = 0; gk < 3; gk++) begin : g_cnt
         logic [2:0] ev_v;
         logic ev_on;
         logic cnt_ev;
         assign ev_v = lane_err[gl];
         assign ev_on = ev_v[gk] && lane_enable[gl] && !decoder_soft_reset;
         assign cnt_ev = clk_en && ev_on && !count_clear[gl][gk];

         a_sat_hold: assert property (@(posedge clock) disable iff (!reset_n)
            (cnt_ev && hold[gl][gk] && err_count[gl][gk] == `LECH_TERMINAL)
            |=> err_count[gl][gk] == `LECH_TERMINAL)
            else $error("held counter moved off terminal count");

         a_roll_over: assert property (@(posedge clock) disable iff (!reset_n)
            (cnt_ev && !hold[gl][gk] && err_count[gl][gk] == `LECH_TERMINAL)
            |=> err_count[gl][gk] == 8'h00)
            else $error("free counter did not roll over");

         a_step_one: assert property (@(posedge clock) disable iff (!reset_n)
            (cnt_ev && err_count[gl][gk] != `LECH_TERMINAL)
            |=> err_count[gl][gk] == $past(err_count[gl][gk]) + 8'h01)
            else $error("counter did not step by one");

         // counting off in soft reset or with the lane disabled
         a_idle_stable: assert property (@(posedge clock) disable iff (!reset_n)
            (clk_en && !ev_on && !count_clear[gl][gk]) |=> $stable(err_count[gl][gk]))
            else $error("counter moved without an error");

         a_clear_wins: assert property (@(posedge clock) disable iff (!reset_n)
            (clk_en && count_clear[gl][gk])
            |=> err_count[gl][gk] == 8'h00 && !sat_flag[gl][gk])
            else $error("clear did not reset counter and flag");

         a_flag_hit: assert property (@(posedge clock) disable iff (!reset_n)
            (err_count[gl][gk] == `LECH_TERMINAL) |-> sat_flag[gl][gk])
            else $error("terminal flag missing");

         a_freeze_off: assert property (@(posedge clock) disable iff (!reset_n)
            (!clk_en) |=> $stable(err_count[gl][gk]) && $stable(sat_flag[gl][gk]))
            else $error("state moved while clock enable low");

      end
   end
endmodule

// ---- design/lech_map.svh ----
`ifndef LECH_MAP_SVH
`define LECH_MAP_SVH
`define LECH_ADDR_W 12
`define LECH_OFS_HOLD4 12'h48C
`define LECH_OFS_HOLD5 12'h48D
`define LECH_OFS_DEC_CTRL 12'h475
`define LECH_DEC_SRST_BIT 3
`define LECH_HOLD_RESET 3'h7
`define LECH_TERMINAL 8'hFF
`define LECH_BIT_UEK 2
`define LECH_BIT_NIT 1
`define LECH_BIT_BDE 0
`endif

// ---- design/lech_pkg.sv ----
package lech_pkg;
   typedef struct packed {
      logic unexpected_control_char_error;
      logic invalid_symbol_error;
      logic running_disparity_error;
   } lech_err_t;
   typedef struct packed {
      logic [2:0] lane4_saturate_enable;
      logic [2:0] lane5_saturate_enable;
      logic decoder_soft_reset;
      logic [5:0][7:0] count;
      logic [1:0][2:0] saturated_flag;
      logic [7:0] rdata;
   } lech_state_t;
endpackage

// ---- tb/lech_link_tx.sv ----
`timescale 1ns/1ps
module lech_link_tx (
   input wire logic clock, // bench clock
   input wire logic go, // load a burst
   input wire logic [8:0] n, // errors in the burst
   input wire logic [1:0][2:0] mask, // counters hit
   output lech_pkg::lech_err_t [1:0] lane_err, // error pulses
   output logic busy // burst under way
);
   logic [8:0] left_q = 9'h000;
   initial lane_err = 6'h00;
   assign busy = go | (left_q != 9'h000);
   always @(posedge clock) begin
      if (go) begin
         left_q <= n;
      end else if (left_q != 9'h000) begin
         left_q <= left_q - 9'h001;
      end
   end
   // one high cycle per error, launched away from the sampling edge
   always @(negedge clock) begin
      lane_err <= (left_q != 9'h000) ? mask : 6'h00;
   end
endmodule

// ---- tb/tb_lech_ctrl.sv ----
`timescale 1ns/1ps
module tb_lech_ctrl;
   logic clock = 0, reset_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, go = 0, busy, dsr;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic [1:0] lane_enable = 2'h0;
   logic [1:0][2:0] count_clear = 6'h00, mask = 6'h00, sat_flag;
   logic [8:0] n = 9'h000;
   logic [47:0] err_count;
   lech_pkg::lech_err_t [1:0] lane_err;
   int n_fail = 0, compares = 0, cyc = 0;
   lech_ctrl lech_ctrl_inst (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .lane_enable(lane_enable), .lane_err(lane_err),
      .count_clear(count_clear), .err_count(err_count), .sat_flag(sat_flag),
      .decoder_soft_reset(dsr));
   lech_link_tx lech_link_tx_inst (.clock(clock), .go(go), .n(n), .mask(mask),
      .lane_err(lane_err), .busy(busy));
   initial forever #2.5 clock = ~clock;
   task automatic close_out;
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         close_out();
      end
   end
   task automatic check(logic [47:0] seen, logic [47:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %h %h", $time, seen, exp);
      end
   endtask
   // strobes drop for a cycle between calls so none is driven twice in one step
   task automatic wr(logic [11:0] a, logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge clock);
      reg_wr = 0;
      @(negedge clock);
   endtask
   task automatic rd(logic [11:0] a, logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1;
      @(negedge clock);
      reg_rd = 0;
      check({40'h0, reg_rdata}, {40'h0, exp});
      @(negedge clock);
   endtask
   task automatic burst(logic [8:0] cnt);
      n = cnt;
      go = 1;
      @(negedge clock);
      go = 0;
      for (int i = 0; i < 300 && busy; i++) @(negedge clock);
      @(negedge clock);
   endtask
   initial begin
      repeat (4) @(negedge clock);
      reset_n = 1;
      rd(12'h48C, 8'h07);
      rd(12'h48D, 8'h07);
      rd(12'h475, 8'h08);
      rd(12'h000, 8'h00);
      wr(12'h48C, 8'hFF);
      rd(12'h48C, 8'h07);
      wr(12'h48C, 8'h03);
      wr(12'h48D, 8'h04);
      rd(12'h48C, 8'h03);
      rd(12'h48D, 8'h04);
      wr(12'h475, 8'h00);
      wr(12'h48C, 8'h07);
      rd(12'h48C, 8'h03);
      check({47'h0, dsr}, 48'h0);
      lane_enable = 2'h3;
      mask = 6'h3F;
      burst(9'h100);
      check(err_count, 48'hFF0000_00FFFF);
      check({42'h0, sat_flag}, 48'h3F);
      burst(9'h001);
      check(err_count, 48'hFF0101_01FFFF);
      count_clear = 6'h3F;
      @(negedge clock);
      count_clear = 6'h00;
      @(negedge clock);
      check(err_count, 48'h0);
      check({42'h0, sat_flag}, 48'h0);
      wr(12'h475, 8'h08);
      burst(9'h002);
      check(err_count, 48'h0);
      wr(12'h475, 8'h00);
      lane_enable = 2'h0;
      burst(9'h002);
      check(err_count, 48'h0);
      lane_enable = 2'h3;
      clk_en = 0;
      burst(9'h002);
      clk_en = 1;
      check(err_count, 48'h0);
      burst(9'h001);
      check(err_count, 48'h010101_010101);
      close_out();
   end
endmodule
